/* verilog/reset_initial_state_control.v */
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "reset_ctrl_map.vh"
module reset_initial_state_control #(
  parameter SRESET_CYC = `SRESET_CYC,
  parameter DLY_W      = 8
) (
  input  wire       i_mclk,
  input  wire       i_sys_rst,
  input  wire       i_lvr_det,
  input  wire       i_wdt_timeout,
  input  wire       i_sleep_mode,
  input  wire       i_sleep_entry,
  input  wire       i_wdt_clear_cmd,
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  output reg        o_core_rst,
  output reg        o_periph_rst,
  output reg        o_pc_sp_clear,
  output reg        o_wdt_tb_clear,
  output reg        o_wdt_run,
  output reg        o_watchdog_timeout_flag,
  output reg        o_powerdown_flag,
  output reg  [7:0] o_port_data,
  output reg  [7:0] o_port_dir,
  output reg  [7:0] o_int_enable,
  output reg  [7:0] o_timer_on,
  output reg        o_irq
);
  // ----------------------------------------
  // reset kinds, one-hot
  // ----------------------------------------
  localparam [5:0] K_NONE    = 6'b000000;
  localparam [5:0] K_LVR     = 6'b000001;
  localparam [5:0] K_WDT_RUN = 6'b000010;
  localparam [5:0] K_WDT_SLP = 6'b000100;
  localparam [5:0] K_GUARD   = 6'b001000;
  localparam [5:0] K_LVSEL   = 6'b010000;
  localparam [5:0] K_POR     = 6'b100000;

  function guard_ok;
    input [7:0] v;
    begin
      guard_ok = (v == `GUARD_OK_A) || (v == `GUARD_OK_B);
    end
  endfunction

  function lvsel_ok;
    input [7:0] v;
    begin
      lvsel_ok = (v == `LVSEL_OK_A) || (v == `LVSEL_OK_B) ||
                 (v == `LVSEL_OK_C) || (v == `LVSEL_OK_D);
    end
  endfunction

  // ----------------------------------------
  // source synchronisation
  // ----------------------------------------
  wire [1:0] src_rise;
  wire       guard_fire;
  wire       lvsel_fire;
  reg        sleep_q;

  reset_source_sync #(
    .W      (2)
  ) u_sync (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_src     ({i_wdt_timeout, i_lvr_det}),
    .o_rise    (src_rise)
  );

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg       to_q;
  reg       pdf_q;
  reg [3:0] cause_q;
  reg [7:0] guard_q;
  reg [7:0] lvsel_q;
  reg [7:0] accum_q;
  reg [7:0] tblp_q;
  reg [5:0] irq_stat_q;
  reg [5:0] irq_mask_q;
  reg [5:0] kind_q;
  reg [5:0] kind_d;

  wire wr_guard = i_wr && (i_addr == `OFS_GUARD);
  wire wr_lvsel = i_wr && (i_addr == `OFS_LVSEL);
  wire any_rst  = (kind_d != K_NONE);

  // a reset of any other kind drops a pending soft-reset wait
  soft_reset_delay #(
    .CW  (DLY_W),
    .CYC (SRESET_CYC)
  ) u_guard_dly (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_start   (wr_guard && !guard_ok(i_wdata)),
    .i_cancel  (any_rst && !kind_d[3]),
    .o_fire    (guard_fire)
  );

  soft_reset_delay #(
    .CW  (DLY_W),
    .CYC (SRESET_CYC)
  ) u_lvsel_dly (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_start   (wr_lvsel && !lvsel_ok(i_wdata)),
    .i_cancel  (any_rst && !kind_d[4]),
    .o_fire    (lvsel_fire)
  );

  // ----------------------------------------
  // source priority
  // ----------------------------------------
  // power-on is i_sys_rst itself and wins by taking the whole block
  always @* begin
    kind_d = K_NONE;
    if (src_rise[0] && !sleep_q) begin
      kind_d = K_LVR;
    end else if (src_rise[1] && sleep_q) begin
      kind_d = K_WDT_SLP;
    end else if (src_rise[1]) begin
      kind_d = K_WDT_RUN;
    end else if (guard_fire) begin
      kind_d = K_GUARD;
    end else if (lvsel_fire) begin
      kind_d = K_LVSEL;
    end
  end

  // ----------------------------------------
  // reset actions and flags
  // ----------------------------------------
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sleep_q                 <= 1'b0;
      kind_q                  <= K_POR;
      to_q                    <= 1'b0;
      pdf_q                   <= 1'b0;
      cause_q                 <= 4'h0;
      guard_q                 <= `GUARD_RST;
      lvsel_q                 <= `LVSEL_RST;
      o_port_data             <= `PORT_RST;
      o_port_dir              <= `PORT_RST;
      o_int_enable            <= `ZERO_RST;
      o_timer_on              <= `ZERO_RST;
      o_core_rst              <= 1'b1;
      o_periph_rst            <= 1'b1;
      o_pc_sp_clear           <= 1'b1;
      o_wdt_tb_clear          <= 1'b1;
      o_wdt_run               <= 1'b0;
      o_watchdog_timeout_flag <= 1'b0;
      o_powerdown_flag        <= 1'b0;
    end else begin
      sleep_q        <= i_sleep_mode;
      kind_q         <= kind_d;
      o_core_rst     <= any_rst;
      o_pc_sp_clear  <= any_rst;
      o_periph_rst   <= any_rst && !kind_d[2];
      o_wdt_tb_clear <= any_rst && !kind_d[2];
      o_wdt_run      <= 1'b1;

      // run-time flag moves: sleep entry and watchdog clear
      if (i_wdt_clear_cmd) begin
        to_q  <= 1'b0;
        pdf_q <= 1'b0;
      end else if (i_sleep_entry) begin
        to_q  <= 1'b0;
        pdf_q <= 1'b1;
      end

      // software writes; only zeros clear cause flags
      if (i_wr) begin
        case (i_addr)
          `OFS_CAUSE:      cause_q      <= cause_q & i_wdata[3:0];
          `OFS_GUARD:      guard_q      <= i_wdata;
          `OFS_LVSEL:      lvsel_q      <= i_wdata;
          `OFS_PORT_DATA:  o_port_data  <= i_wdata;
          `OFS_PORT_DIR:   o_port_dir   <= i_wdata;
          `OFS_INT_EN:     o_int_enable <= i_wdata;
          `OFS_TIMER_CTRL: o_timer_on   <= i_wdata;
          default:         cause_q      <= cause_q;
        endcase
      end

      // reset kinds override; set wins over a same-cycle clear
      case (kind_d)
        K_LVR: begin
          cause_q[`CAUSE_LV_BIT] <= 1'b1;
          o_port_data            <= `PORT_RST;
          o_port_dir             <= `PORT_RST;
          o_int_enable           <= `ZERO_RST;
          o_timer_on             <= `ZERO_RST;
          guard_q                <= `GUARD_RST;
          lvsel_q                <= lvsel_q;
          to_q                   <= to_q;
          pdf_q                  <= pdf_q;
        end
        K_WDT_RUN: begin
          to_q         <= 1'b1;
          pdf_q        <= pdf_q;
          o_port_data  <= `PORT_RST;
          o_port_dir   <= `PORT_RST;
          o_int_enable <= `ZERO_RST;
          o_timer_on   <= `ZERO_RST;
          guard_q      <= `GUARD_RST;
          lvsel_q      <= `LVSEL_RST;
        end
        K_WDT_SLP: begin
          to_q  <= 1'b1;
          pdf_q <= 1'b1;
        end
        K_GUARD: begin
          cause_q[`CAUSE_GUARD_BIT] <= 1'b1;
          o_port_data               <= `PORT_RST;
          o_port_dir                <= `PORT_RST;
          o_int_enable              <= `ZERO_RST;
          o_timer_on                <= `ZERO_RST;
          guard_q                   <= `GUARD_RST;
        end
        K_LVSEL: begin
          cause_q[`CAUSE_LVSEL_BIT] <= 1'b1;
          o_port_data               <= `PORT_RST;
          o_port_dir                <= `PORT_RST;
          o_int_enable              <= `ZERO_RST;
          o_timer_on                <= `ZERO_RST;
          guard_q                   <= `GUARD_RST;
          lvsel_q                   <= `LVSEL_RST;
        end
        default: begin
          kind_q <= kind_d;
        end
      endcase

      o_watchdog_timeout_flag <= to_q;
      o_powerdown_flag        <= pdf_q;
    end
  end

  // ----------------------------------------
  // accumulator and table pointer
  // ----------------------------------------
  // deliberately no reset: power-on leaves them undefined
  always @(posedge i_mclk) begin
    if (i_wr && (i_addr == `OFS_ACCUM)) begin
      accum_q <= i_wdata;
    end
    if (i_wr && (i_addr == `OFS_TBL_PTR)) begin
      tblp_q <= i_wdata;
    end
  end

  // ----------------------------------------
  // interrupt status, mask, read data
  // ----------------------------------------
  wire       rd_irq = i_rd && (i_addr == `OFS_IRQ_STAT);
  wire [5:0] irq_set;

  assign irq_set = kind_d[5:0] & 6'b011111;

  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      irq_stat_q <= 6'h01;
      irq_mask_q <= 6'h00;
      o_irq      <= 1'b0;
      o_rdata    <= 8'h00;
    end else begin
      // event in the clearing cycle survives the read
      irq_stat_q <= (rd_irq ? 6'h00 : irq_stat_q) |
                    {irq_set[4:0], 1'b0};
      if (i_wr && (i_addr == `OFS_IRQ_MASK)) begin
        irq_mask_q <= i_wdata[5:0];
      end
      o_irq   <= |(((rd_irq ? 6'h00 : irq_stat_q) |
                    {irq_set[4:0], 1'b0}) & irq_mask_q);
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `OFS_STATUS:     o_rdata <= {2'b00, to_q, pdf_q, 4'h0};
          `OFS_CAUSE:      o_rdata <= {4'h0, cause_q};
          `OFS_GUARD:      o_rdata <= guard_q;
          `OFS_LVSEL:      o_rdata <= lvsel_q;
          `OFS_PORT_DATA:  o_rdata <= o_port_data;
          `OFS_PORT_DIR:   o_rdata <= o_port_dir;
          `OFS_INT_EN:     o_rdata <= o_int_enable;
          `OFS_TIMER_CTRL: o_rdata <= o_timer_on;
          `OFS_ACCUM:      o_rdata <= accum_q;
          `OFS_TBL_PTR:    o_rdata <= tblp_q;
          `OFS_IRQ_STAT:   o_rdata <= {2'b00, irq_stat_q};
          `OFS_IRQ_MASK:   o_rdata <= {2'b00, irq_mask_q};
          default:         o_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

/* inc/reset_ctrl_map.vh */
`ifndef RESET_CTRL_MAP_VH
`define RESET_CTRL_MAP_VH

// register offsets
`define OFS_STATUS      4'h0
`define OFS_CAUSE       4'h1
`define OFS_GUARD       4'h2
`define OFS_LVSEL       4'h3
`define OFS_PORT_DATA   4'h4
`define OFS_PORT_DIR    4'h5
`define OFS_INT_EN      4'h6
`define OFS_TIMER_CTRL  4'h7
`define OFS_ACCUM       4'h8
`define OFS_TBL_PTR     4'h9
`define OFS_IRQ_STAT    4'ha
`define OFS_IRQ_MASK    4'hb

// status word fields
`define STAT_TO_BIT     5
`define STAT_PDF_BIT    4

// reset cause flag fields
`define CAUSE_GUARD_BIT 3
`define CAUSE_LV_BIT    2
`define CAUSE_LVSEL_BIT 1
`define CAUSE_WDT_BIT   0

// interrupt status fields
`define IRQ_POR_BIT     0
`define IRQ_LVR_BIT     1
`define IRQ_WDT_RUN_BIT 2
`define IRQ_WDT_SLP_BIT 3
`define IRQ_GUARD_BIT   4
`define IRQ_LVSEL_BIT   5

// reset and legal values
`define GUARD_RST       8'h55
`define GUARD_OK_A      8'h55
`define GUARD_OK_B      8'haa
`define LVSEL_RST       8'h55
`define LVSEL_OK_A      8'h55
`define LVSEL_OK_B      8'h33
`define LVSEL_OK_C      8'h99
`define LVSEL_OK_D      8'haa
`define PORT_RST        8'hff
`define ZERO_RST        8'h00

// timing
`define CLK_MHZ         25
`define SRESET_TIME_NS  1000
`define SRESET_CYC      ((`SRESET_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

/* verilog/reset_source_sync.v */
`timescale 1ns/1ps
// ----------------------------------------
// two-flop synchroniser with rise detect
// ----------------------------------------
module reset_source_sync #(
  parameter W = 3
) (
  input  wire         i_mclk,
  input  wire         i_sys_rst,
  input  wire [W-1:0] i_src,
  output wire [W-1:0] o_rise
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  reg [W-1:0] last_q;

  // only sync_q looks at meta_q
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
      last_q <= {W{1'b0}};
    end else begin
      meta_q <= i_src;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign o_rise = sync_q & ~last_q;
endmodule

/* verilog/soft_reset_delay.v */
`timescale 1ns/1ps
// ----------------------------------------
// delay from bad register load to reset
// ----------------------------------------
module soft_reset_delay #(
  parameter CW  = 8,
  parameter CYC = 25
) (
  input  wire i_mclk,
  input  wire i_sys_rst,
  input  wire i_start,
  input  wire i_cancel,
  output reg  o_fire
);
  reg [CW-1:0] cnt_q;
  reg          busy_q;

  // a second bad load while counting does not restart the wait
  always @(posedge i_mclk) begin
    if (i_sys_rst || i_cancel) begin
      cnt_q  <= {CW{1'b0}};
      busy_q <= 1'b0;
      o_fire <= 1'b0;
    end else begin
      o_fire <= 1'b0;
      if (busy_q) begin
        if (cnt_q == CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
          busy_q <= 1'b0;
          o_fire <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
      end else if (i_start) begin
        busy_q <= 1'b1;
        cnt_q  <= {CW{1'b0}};
      end
    end
  end
endmodule

/* sim/reset_state_checker.sv */
`timescale 1ns/1ps
`include "reset_ctrl_map.vh"
module reset_state_checker #(
  parameter SRESET_CYC = 4
) (
  input wire       i_mclk,
  input wire       i_sys_rst,
  input wire       i_wr,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       o_core_rst,
  input wire       o_periph_rst,
  input wire       o_pc_sp_clear,
  input wire       o_wdt_tb_clear,
  input wire       o_wdt_run,
  input wire       o_watchdog_timeout_flag,
  input wire       o_powerdown_flag,
  input wire [7:0] o_port_data,
  input wire [7:0] o_port_dir,
  input wire [7:0] o_int_enable,
  input wire [7:0] o_timer_on
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // slack of three cycles: synchroniser depth is not fixed by the rules
  localparam int SR_LO = SRESET_CYC;
  localparam int SR_HI = SRESET_CYC + 3;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  wire sleep_rst = o_pc_sp_clear && !o_periph_rst;
  wire bad_guard = i_wr && i_addr == `OFS_GUARD &&
                   i_wdata != `GUARD_OK_A && i_wdata != `GUARD_OK_B;

  property p_por_state;
    $fell(i_sys_rst) |-> o_core_rst && o_port_data == 8'hff &&
      o_port_dir == 8'hff && o_int_enable == 8'h00 &&
      o_timer_on == 8'h00 && !o_watchdog_timeout_flag && !o_powerdown_flag
      ##1 !o_core_rst && o_wdt_run;
  endproperty
  a_por_state: assert property (p_por_state)
    else $error("power-on state wrong");
  property p_pc_on_periph;
    o_periph_rst |-> o_pc_sp_clear;
  endproperty
  a_pc_on_periph: assert property (p_pc_on_periph)
    else $error("peripheral reset without pc clear");
  property p_wdt_clear;
    o_wdt_tb_clear == o_periph_rst;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear)
    else $error("watchdog clear not with peripheral reset");
  property p_ports_in;
    o_periph_rst |-> ##[0:1] (o_port_data == 8'hff && o_port_dir == 8'hff);
  endproperty
  a_ports_in: assert property (p_ports_in)
    else $error("ports not inputs after reset");
  property p_int_tmr_off;
    o_periph_rst |-> ##[0:1] (o_int_enable == 8'h00 && o_timer_on == 8'h00);
  endproperty
  a_int_tmr_off: assert property (p_int_tmr_off)
    else $error("interrupts or timers on after reset");
  property p_wdt_restart;
    $fell(o_core_rst) |-> ##[0:1] o_wdt_run;
  endproperty
  a_wdt_restart: assert property (p_wdt_restart)
    else $error("watchdog not running after reset");
  property p_sleep_keep;
    sleep_rst |-> $stable(o_port_data) && $stable(o_int_enable)
      ##1 $stable(o_port_data) && $stable(o_timer_on);
  endproperty
  a_sleep_keep: assert property (p_sleep_keep)
    else $error("sleep watchdog reset changed state");
  property p_sleep_flags;
    sleep_rst |-> ##[0:2] (o_watchdog_timeout_flag && o_powerdown_flag);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep watchdog flags not set");
  property p_guard_fire;
    bad_guard |-> ##[SR_LO:SR_HI] o_core_rst;
  endproperty
  a_guard_fire: assert property (p_guard_fire)
    else $error("bad guard value did not reset");
endmodule

bind reset_initial_state_control reset_state_checker #(
  .SRESET_CYC(SRESET_CYC)
) chk_u (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_wr(i_wr),
  .i_addr(i_addr), .i_wdata(i_wdata), .o_core_rst(o_core_rst),
  .o_periph_rst(o_periph_rst), .o_pc_sp_clear(o_pc_sp_clear),
  .o_wdt_tb_clear(o_wdt_tb_clear), .o_wdt_run(o_wdt_run),
  .o_watchdog_timeout_flag(o_watchdog_timeout_flag),
  .o_powerdown_flag(o_powerdown_flag), .o_port_data(o_port_data),
  .o_port_dir(o_port_dir), .o_int_enable(o_int_enable),
  .o_timer_on(o_timer_on)
);

/* sim/tb.sv */
`timescale 1ns/1ps
`include "reset_ctrl_map.vh"
module tb;
  logic       i_mclk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       i_lvr_det = 1'b0;
  logic       i_wdt_timeout = 1'b0;
  logic       i_sleep_mode = 1'b0;
  logic       i_sleep_entry = 1'b0;
  logic       i_wdt_clear_cmd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  wire  [7:0] o_rdata, o_port_data, o_port_dir, o_int_enable, o_timer_on;
  wire        o_core_rst, o_periph_rst, o_pc_sp_clear, o_wdt_tb_clear;
  wire        o_wdt_run, o_watchdog_timeout_flag, o_powerdown_flag, o_irq;
  integer     failures = 0;
  integer     samples_checked = 0;

  reset_initial_state_control #(.SRESET_CYC(4)) dut_u (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_lvr_det(i_lvr_det),
    .i_wdt_timeout(i_wdt_timeout), .i_sleep_mode(i_sleep_mode),
    .i_sleep_entry(i_sleep_entry), .i_wdt_clear_cmd(i_wdt_clear_cmd),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_core_rst(o_core_rst), .o_periph_rst(o_periph_rst),
    .o_pc_sp_clear(o_pc_sp_clear), .o_wdt_tb_clear(o_wdt_tb_clear),
    .o_wdt_run(o_wdt_run), .o_watchdog_timeout_flag(o_watchdog_timeout_flag),
    .o_powerdown_flag(o_powerdown_flag), .o_port_data(o_port_data),
    .o_port_dir(o_port_dir), .o_int_enable(o_int_enable),
    .o_timer_on(o_timer_on), .o_irq(o_irq)
  );

  initial begin
    forever #20 i_mclk = ~i_mclk;
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task wrap_up;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  // each access starts on a fresh edge so strobes never double up
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task rchk(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge i_mclk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(nm, e, o_rdata);
    @(posedge i_mclk);
    #1 chk("rdata idle", 8'h00, o_rdata);
  endtask
  task wpc;
    integer n;
    n = 0;
    do begin @(posedge i_mclk); #1; n++; end
    while (o_pc_sp_clear !== 1'b1 && n < 20);
    if (o_pc_sp_clear !== 1'b1) begin
      $display("unexpected reset pulse expected 1 seen 0");
      failures++;
      wrap_up;
    end
  endtask
  task ev(input logic lv, input logic wd, input logic per);
    @(posedge i_mclk);
    i_lvr_det <= lv; i_wdt_timeout <= wd;
    wpc;
    chk("periph_rst", per, o_periph_rst);
    @(posedge i_mclk);
    i_lvr_det <= 1'b0; i_wdt_timeout <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
  task flg(input logic t, input logic p);
    #1 chk("timeout flag", t, o_watchdog_timeout_flag);
    chk("powerdown flag", p, o_powerdown_flag);
    rchk(`OFS_STATUS, {2'b00, t, p, 4'h0}, "status");
  endtask
  task sp(input logic ent);
    @(posedge i_mclk);
    if (ent) i_sleep_entry <= 1'b1;
    else i_wdt_clear_cmd <= 1'b1;
    @(posedge i_mclk);
    i_sleep_entry <= 1'b0; i_wdt_clear_cmd <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1 chk("port data", 8'hff, o_port_data);
    chk("port dir", 8'hff, o_port_dir);
    chk("int enable", 8'h00, o_int_enable);
    chk("timer on", 8'h00, o_timer_on);
    chk("wdt run", 1'b1, o_wdt_run);
    flg(1'b0, 1'b0);
    rchk(`OFS_GUARD, `GUARD_RST, "guard");
    rchk(`OFS_LVSEL, `LVSEL_RST, "lvsel");
    // a set mask bit lets its status bit through to the interrupt line
    wr(`OFS_IRQ_MASK, 8'h00);
    @(posedge i_mclk);
    #1 chk("irq masked", 8'h00, {7'h00, o_irq});
    wr(`OFS_IRQ_MASK, 8'hff);
    @(posedge i_mclk);
    #1 chk("irq unmasked", 8'h01, {7'h00, o_irq});
    rchk(`OFS_IRQ_STAT, 8'h01, "irq stat");
    @(posedge i_mclk);
    #1 chk("irq after clear", 1'b0, o_irq);
    rchk(`OFS_IRQ_STAT, 8'h00, "irq stat cleared");
    wr(`OFS_STATUS, 8'hff);
    rchk(`OFS_STATUS, 8'h00, "status read only");
    wr(4'hc, 8'h5a);
    rchk(4'hc, 8'h00, "unmapped");
    // low-voltage and watchdog together: low voltage must win
    sp(1'b1);
    flg(1'b0, 1'b1);
    wr(`OFS_LVSEL, `LVSEL_OK_B);
    wr(`OFS_PORT_DATA, 8'h12);
    wr(`OFS_INT_EN, 8'h0f);
    wr(`OFS_TIMER_CTRL, 8'h03);
    wr(`OFS_ACCUM, 8'h5a);
    ev(1'b1, 1'b1, 1'b1);
    flg(1'b0, 1'b1);
    rchk(`OFS_LVSEL, `LVSEL_OK_B, "lvsel kept");
    rchk(`OFS_CAUSE, 8'h04, "cause lowvolt");
    rchk(`OFS_ACCUM, 8'h5a, "accum kept");
    chk("port data", 8'hff, o_port_data);
    chk("int enable", 8'h00, o_int_enable);
    chk("timer on", 8'h00, o_timer_on);
    wr(`OFS_PORT_DATA, 8'h12);
    ev(1'b0, 1'b1, 1'b1);
    flg(1'b1, 1'b1);
    rchk(`OFS_LVSEL, `LVSEL_RST, "lvsel restored");
    chk("port data", 8'hff, o_port_data);
    sp(1'b0);
    flg(1'b0, 1'b0);
    i_sleep_mode <= 1'b1;
    wr(`OFS_PORT_DATA, 8'h12);
    wr(`OFS_INT_EN, 8'h0f);
    ev(1'b0, 1'b1, 1'b0);
    flg(1'b1, 1'b1);
    chk("port kept", 8'h12, o_port_data);
    chk("int kept", 8'h0f, o_int_enable);
    i_sleep_mode <= 1'b0;
    wr(`OFS_CAUSE, 8'h00);
    wr(`OFS_GUARD, `GUARD_OK_B);
    repeat (10) @(posedge i_mclk);
    rchk(`OFS_CAUSE, 8'h00, "cause after good guard");
    wr(`OFS_GUARD, 8'h12);
    wpc;
    repeat (4) @(posedge i_mclk);
    rchk(`OFS_CAUSE, 8'h08, "cause guard");
    wr(`OFS_LVSEL, 8'h07);
    wpc;
    repeat (4) @(posedge i_mclk);
    rchk(`OFS_CAUSE, 8'h0a, "cause lvsel");
    rchk(`OFS_LVSEL, `LVSEL_RST, "lvsel reverted");
    wrap_up;
  end
endmodule
